/* oesc_output_enable_sideband_ctrl.sv */
// Output-enable control of a multi-output clock buffer: pin enables,
// management enable bits, serial sideband load, power-down and address strap.
// Assumes pins are asynchronous to clk_sys; the sideband data and load
// pins change only away from rising edges of the sideband clock.
//
// Overview of operation
// - Sideband off: channel 6 pin is an active-low enable of channel 6.
// - Sideband on: channel 6 pin is the sideband serial clock, not an enable.
// - Sideband off: pins of channels 7, 8, 9, 11, 12 enable their channel when low.
// - Sideband off: shift-load pin is an active-low enable of channel 10.
// - Sideband on: shift-load low freezes the shift register, high lets it shift.
// - Sideband on: shift-load falling edge copies the shift register into the output register.
// - Sideband select low: pins and management enable bits decide the outputs.
// - Sideband select high: only the sideband output register and power-down decide the outputs.
// - Three-level strap bit 0 decoded with strap bit 1 selects the bus address.
// - Sideband on: channel 5 pin is the serial data line.
// - After first power-good high, power-good low tri-states every channel.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

module oesc_output_enable_sideband_ctrl #(
  parameter int NUM_CH = oesc_pkg::NUM_CH
)
(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [oesc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [oesc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [oesc_pkg::DATA_W-1:0] reg_rdata,
  // Enable and sideband pins
  input wire logic ch5_enable_n_or_sb_data,
  input wire logic ch6_enable_n_or_sb_clock,
  input wire logic ch7_enable_n,
  input wire logic ch8_enable_n,
  input wire logic ch9_enable_n,
  input wire logic ch10_enable_n_or_load,
  input wire logic ch11_enable_n,
  input wire logic ch12_enable_n,
  input wire logic sideband_select,
  input wire logic power_good_powerdown_n,
  // Three-level straps, each as a high and a low comparator output
  input wire logic addr_strap_bit0_high,
  input wire logic addr_strap_bit0_low,
  input wire logic addr_strap_bit1_high,
  input wire logic addr_strap_bit1_low,
  // Channel control outputs
  output logic [NUM_CH-1:0] ch_enable,
  output logic powerdown,
  output logic [6:0] smbus_addr
);

  // Decodes a three-level strap from its two comparator outputs
  function automatic oesc_pkg::oesc_level_e strap_level(input logic hi, input logic lo);
    oesc_pkg::oesc_level_e lvl;
    lvl = oesc_pkg::LVL_MID;
    if (hi)
      lvl = oesc_pkg::LVL_HIGH;
    else if (lo)
      lvl = oesc_pkg::LVL_LOW;
    return lvl;
  endfunction

  // Spreads the channel vector onto a register-width word
  function automatic logic [oesc_pkg::DATA_W-1:0] widen(input logic [NUM_CH-1:0] v);
    logic [oesc_pkg::DATA_W-1:0] w;
    w = '0;
    w[NUM_CH-1:0] = v;
    return w;
  endfunction

  // Power-down is armed only once power-good has been seen high
  function automatic logic pd_active(input logic seen, input logic pg_n);
    return seen && !pg_n;
  endfunction

  // ---------------------------------------------------------------
  // Link domain: sideband shift register on the sideband clock
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] sb_shift_r;
  logic [NUM_CH-1:0] sb_shift_nxt;

  always_comb
  begin
    sb_shift_nxt = sb_shift_r;
    // Load and data are driven relative to this clock, so no synchroniser
    if (ch10_enable_n_or_load)
      sb_shift_nxt = {sb_shift_r[NUM_CH-2:0], ch5_enable_n_or_sb_data};
  end

  // Clocked by the channel 6 pin; it may stand still outside a frame
  always_ff @(posedge ch6_enable_n_or_sb_clock)
  begin
    sb_shift_r <= sb_shift_nxt;
  end

  // ---------------------------------------------------------------
  // System domain: pin synchronisers
  // ---------------------------------------------------------------
  logic [oesc_pkg::PIN_W-1:0] pin_raw;
  logic [oesc_pkg::PIN_W-1:0] pin_meta_r;
  logic [oesc_pkg::PIN_W-1:0] pin_sync_r;

  always_comb
  begin
    pin_raw = '0;
    pin_raw[oesc_pkg::NUM_PIN_CH-1:0] = {ch12_enable_n, ch11_enable_n,
      ch10_enable_n_or_load, ch9_enable_n, ch8_enable_n, ch7_enable_n,
      ch6_enable_n_or_sb_clock, ch5_enable_n_or_sb_data};
    pin_raw[oesc_pkg::PIN_SB_SEL] = sideband_select;
    pin_raw[oesc_pkg::PIN_PG] = power_good_powerdown_n;
    pin_raw[oesc_pkg::PIN_S0_HI] = addr_strap_bit0_high;
    pin_raw[oesc_pkg::PIN_S0_LO] = addr_strap_bit0_low;
    pin_raw[oesc_pkg::PIN_S1_HI] = addr_strap_bit1_high;
    pin_raw[oesc_pkg::PIN_S1_LO] = addr_strap_bit1_low;
  end

  // Reset to low, matching the pulldowns of undriven pins
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  logic sb_sel;
  logic load_n;
  assign sb_sel = pin_sync_r[oesc_pkg::PIN_SB_SEL];
  assign load_n = pin_sync_r[oesc_pkg::FIRST_PIN_CH + oesc_pkg::CH10_PIN_IDX
    - oesc_pkg::FIRST_PIN_CH];

  // ---------------------------------------------------------------
  // System domain: control state
  // ---------------------------------------------------------------
  logic load_d_r;
  logic load_d_nxt;
  logic [NUM_CH-1:0] sb_out_r;
  logic [NUM_CH-1:0] sb_out_nxt;
  logic [NUM_CH-1:0] mgmt_en_r;
  logic [NUM_CH-1:0] mgmt_en_nxt;
  logic pg_seen_r;
  logic pg_seen_nxt;
  logic strap_ok_r;
  logic strap_ok_nxt;
  logic [3:0] strap_idx_r;
  logic [3:0] strap_idx_nxt;
  logic [1:0] fill_r;
  logic [1:0] fill_nxt;
  logic [6:0] smbus_addr_nxt;
  logic [NUM_CH-1:0] ch_enable_nxt;
  logic powerdown_nxt;
  logic [oesc_pkg::DATA_W-1:0] reg_rdata_nxt;
  logic [NUM_CH-1:0] pin_en;
  oesc_pkg::oesc_level_e lvl0;
  oesc_pkg::oesc_level_e lvl1;

  always_comb
  begin
    load_d_nxt = load_n;
    sb_out_nxt = sb_out_r;
    // The shift register is frozen while load is low, so the word is stable
    // by the time the synchronised falling edge is seen here
    if (sb_sel && load_d_r && !load_n)
      sb_out_nxt = sb_shift_r;
    mgmt_en_nxt = mgmt_en_r;
    if (reg_wr && reg_addr == oesc_pkg::REG_MGMT_EN)
      mgmt_en_nxt = reg_wdata[NUM_CH-1:0];
    pg_seen_nxt = pg_seen_r | pin_sync_r[oesc_pkg::PIN_PG];
    powerdown_nxt = pd_active(pg_seen_r, pin_sync_r[oesc_pkg::PIN_PG]);
  end

  // Synchronisers restart from zero in reset, so the straps are taken
  // only after two edges have filled them with real pin levels
  always_comb
  begin
    lvl0 = strap_level(pin_sync_r[oesc_pkg::PIN_S0_HI], pin_sync_r[oesc_pkg::PIN_S0_LO]);
    lvl1 = strap_level(pin_sync_r[oesc_pkg::PIN_S1_HI], pin_sync_r[oesc_pkg::PIN_S1_LO]);
    fill_nxt = {fill_r[0], 1'b1};
    strap_ok_nxt = strap_ok_r | fill_r[1];
    strap_idx_nxt = strap_idx_r;
    smbus_addr_nxt = smbus_addr;
    if (!strap_ok_r && fill_r[1])
    begin
      strap_idx_nxt = 4'(lvl1) * oesc_pkg::LEVEL_COUNT + 4'(lvl0);
      smbus_addr_nxt = oesc_pkg::SMB_ADDR_BASE + 7'(strap_idx_nxt);
    end
  end

  // Channel enables, 1 means the output runs
  always_comb
  begin
    pin_en = '1;
    for (int k = 0; k < oesc_pkg::NUM_PIN_CH; k++)
      pin_en[oesc_pkg::FIRST_PIN_CH + k] = !pin_sync_r[k];
    if (pd_active(pg_seen_r, pin_sync_r[oesc_pkg::PIN_PG]))
      ch_enable_nxt = '0;
    else if (sb_sel)
      ch_enable_nxt = sb_out_r;
    else
      ch_enable_nxt = pin_en & mgmt_en_r;
  end

  // Read data, valid in the cycle after the read strobe only
  always_comb
  begin
    reg_rdata_nxt = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        oesc_pkg::REG_MGMT_EN:
          reg_rdata_nxt = widen(mgmt_en_r);
        oesc_pkg::REG_STATUS:
        begin
          reg_rdata_nxt[oesc_pkg::ST_SB_SEL] = sb_sel;
          reg_rdata_nxt[oesc_pkg::ST_PD] = powerdown;
          reg_rdata_nxt[oesc_pkg::ST_PG_SEEN] = pg_seen_r;
          reg_rdata_nxt[oesc_pkg::ST_STRAP_OK] = strap_ok_r;
        end
        oesc_pkg::REG_EFFECTIVE:
          reg_rdata_nxt = widen(ch_enable);
        oesc_pkg::REG_SB_OUT:
          reg_rdata_nxt = widen(sb_out_r);
        oesc_pkg::REG_STRAP:
        begin
          reg_rdata_nxt[oesc_pkg::STRAP_ADDR_LSB +: 7] = smbus_addr;
          reg_rdata_nxt[oesc_pkg::STRAP_IDX_LSB +: 4] = strap_idx_r;
        end
        default:
          reg_rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      load_d_r <= 1'b0;
      sb_out_r <= oesc_pkg::SB_OUT_RESET;
      mgmt_en_r <= oesc_pkg::MGMT_EN_RESET;
      pg_seen_r <= 1'b0;
      strap_ok_r <= 1'b0;
      fill_r <= '0;
      strap_idx_r <= '0;
      smbus_addr <= '0;
      ch_enable <= '0;
      powerdown <= 1'b0;
      reg_rdata <= '0;
    end
    else
    begin
      load_d_r <= load_d_nxt;
      sb_out_r <= sb_out_nxt;
      mgmt_en_r <= mgmt_en_nxt;
      pg_seen_r <= pg_seen_nxt;
      strap_ok_r <= strap_ok_nxt;
      fill_r <= fill_nxt;
      strap_idx_r <= strap_idx_nxt;
      smbus_addr <= smbus_addr_nxt;
      ch_enable <= ch_enable_nxt;
      powerdown <= powerdown_nxt;
      reg_rdata <= reg_rdata_nxt;
    end
  end

endmodule

/* oesc_pkg.sv */
// Constants shared by the output-enable and sideband control block.
// Assumes a plain register port with 8-bit byte addresses and 32-bit data.
package oesc_pkg;

  // Channel layout
  localparam int NUM_CH = 20;
  localparam int FIRST_PIN_CH = 5;
  localparam int NUM_PIN_CH = 8;
  localparam int CH6_PIN_IDX = 1;
  localparam int CH10_PIN_IDX = 5;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_MGMT_EN = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EFFECTIVE = 8'h08;
  localparam logic [7:0] REG_SB_OUT = 8'h0c;
  localparam logic [7:0] REG_STRAP = 8'h10;

  // Reset values
  localparam logic [19:0] MGMT_EN_RESET = 20'hfffff;
  localparam logic [19:0] SB_OUT_RESET = 20'hfffff;

  // Status register fields
  localparam int ST_SB_SEL = 0;
  localparam int ST_PD = 1;
  localparam int ST_PG_SEEN = 2;
  localparam int ST_STRAP_OK = 3;

  // Strap register fields
  localparam int STRAP_ADDR_LSB = 0;
  localparam int STRAP_IDX_LSB = 8;

  // Synchronised pin vector layout
  localparam int PIN_SB_SEL = 8;
  localparam int PIN_PG = 9;
  localparam int PIN_S0_HI = 10;
  localparam int PIN_S0_LO = 11;
  localparam int PIN_S1_HI = 12;
  localparam int PIN_S1_LO = 13;
  localparam int PIN_W = 14;

  // Management address base, arbitrary neutral value
  localparam logic [6:0] SMB_ADDR_BASE = 7'h50;
  localparam logic [3:0] LEVEL_COUNT = 4'h3;

  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} oesc_level_e;

endpackage

/* oesc_properties.sv */
// Port assertions for the output-enable and sideband control block.
// Assumes it is bound to that block and sees only its ports.
`timescale 1ns/1ns
module oesc_properties #(
  parameter int NUM_CH = 20
)
(
  // Clock, reset, register port
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins
  input wire logic ch6_enable_n_or_sb_clock,
  input wire logic ch7_enable_n,
  input wire logic ch10_enable_n_or_load,
  input wire logic ch12_enable_n,
  input wire logic sideband_select,
  input wire logic power_good_powerdown_n,
  // Outputs
  input wire logic [NUM_CH-1:0] ch_enable,
  input wire logic powerdown
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Six samples cover two synchroniser stages and the output register
  a_pd_all_off: assert property (powerdown |-> ch_enable == '0)
    else $error("channel runs in power-down");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  a_ch6_pin_off: assert property ((!sideband_select && ch6_enable_n_or_sb_clock)[*6]
    |-> !ch_enable[6]) else $error("channel 6 pin ignored");
  a_ch7_pin_off: assert property ((!sideband_select && ch7_enable_n)[*6]
    |-> !ch_enable[7]) else $error("channel 7 pin ignored");
  a_ch12_pin_off: assert property ((!sideband_select && ch12_enable_n)[*6]
    |-> !ch_enable[12]) else $error("channel 12 pin ignored");
  a_ch10_pin_off: assert property ((!sideband_select && ch10_enable_n_or_load)[*6]
    |-> !ch_enable[10]) else $error("channel 10 pin ignored");
  a_pg_low_pd: assert property (power_good_powerdown_n[*4] ##1
    !power_good_powerdown_n[*6] |-> powerdown) else $error("no power-down");
  // No load fall means nothing may move the outputs in sideband mode
  a_sb_holds_out: assert property ((sideband_select && !ch10_enable_n_or_load
    && power_good_powerdown_n)[*8] |-> $stable(ch_enable))
    else $error("outputs moved without commit");
endmodule
bind oesc_output_enable_sideband_ctrl oesc_properties #(.NUM_CH(NUM_CH)) i_props (
  .clk_sys, .rst_n, .reg_rd, .reg_rdata, .ch6_enable_n_or_sb_clock, .ch7_enable_n,
  .ch10_enable_n_or_load, .ch12_enable_n, .sideband_select, .power_good_powerdown_n,
  .ch_enable, .powerdown
);

/* oesc_sb_host.sv */
// Host model of the serial sideband: clock, data and load lines.
// Assumes the bench routes these onto the shared pins in sideband mode.
`timescale 1ns/1ns
module oesc_sb_host (
  // Link lines
  output logic sb_clk,
  output logic sb_dat,
  output logic sb_ld
);
  initial
  begin
    sb_clk = 1'b0;
    sb_dat = 1'b0;
    sb_ld = 1'b0;
  end
  // Low n bits of p, top bit first, 80 ns period; ld low never commits
  task automatic send(input logic [19:0] p, input int n, input logic ld);
    // Callers return on a system clock edge; step off it before touching a line
    #1;
    sb_ld = ld;
    for (int i = n - 1; i >= 0; i--)
    begin
      #20 sb_dat = p[i];
      #20 sb_clk = 1'b1;
      #40 sb_clk = 1'b0;
    end
    // Clock stands still, data falls to its pulldown level
    #20 sb_dat = 1'b0;
    sb_ld = 1'b0;
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the output-enable and sideband control block.
// Assumes a 250 MHz system clock; the host model drives the link.
`timescale 1ns/1ns
module tb;
  localparam logic [19:0] PA = 20'ha5c3e;
  localparam logic [19:0] PB = 20'h5a3c1;
  localparam logic [19:0] PC = 20'h0f0f0;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] pin = 8'h00;
  logic sb_mode = 1'b0;
  logic pg = 1'b0;
  // Strap 0 mid, strap 1 high
  logic [3:0] strap = 4'h4;
  logic [19:0] ch_enable;
  logic powerdown;
  logic [6:0] smbus_addr;
  logic h_clk, h_dat, h_ld;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #2 clk_sys = ~clk_sys;
  oesc_sb_host i_host (.sb_clk(h_clk), .sb_dat(h_dat), .sb_ld(h_ld));
  oesc_output_enable_sideband_ctrl i_dut (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ch5_enable_n_or_sb_data(sb_mode ? h_dat : pin[0]),
    .ch6_enable_n_or_sb_clock(sb_mode ? h_clk : pin[1]),
    .ch7_enable_n(pin[2]), .ch8_enable_n(pin[3]), .ch9_enable_n(pin[4]),
    .ch10_enable_n_or_load(sb_mode ? h_ld : pin[5]),
    .ch11_enable_n(pin[6]), .ch12_enable_n(pin[7]),
    .sideband_select(sb_mode), .power_good_powerdown_n(pg),
    .addr_strap_bit0_high(strap[0]), .addr_strap_bit0_low(strap[1]),
    .addr_strap_bit1_high(strap[2]), .addr_strap_bit1_low(strap[3]),
    .ch_enable, .powerdown, .smbus_addr
  );
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 cmp(n, e, reg_rdata);
  endtask
  // Pins pass two synchronisers; eight cycles leave margin
  task automatic setpin(input logic [7:0] v, input logic m);
    @(posedge clk_sys);
    pin <= v;
    sb_mode <= m;
    repeat (8) @(posedge clk_sys);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 cmp("addr", {25'h0, oesc_pkg::SMB_ADDR_BASE + 7'h07}, {25'h0, smbus_addr});
    cmp("pd", 32'h0, {31'h0, powerdown});
    chk(oesc_pkg::REG_STRAP, {20'h0, 4'h7, 1'b0, oesc_pkg::SMB_ADDR_BASE + 7'h07}, "strap");
    chk(oesc_pkg::REG_MGMT_EN, 32'hfffff, "mgmt");
    chk(oesc_pkg::REG_STATUS, 32'h8, "status");
    chk(8'h14, 32'h0, "unmapped");
    wr(oesc_pkg::REG_EFFECTIVE, 32'h0);
    pg <= 1'b1;
    setpin(8'h00, 1'b0);
    cmp("en", 32'hfffff, {12'h0, ch_enable});
    for (int i = 0; i < 8; i++)
    begin
      setpin(8'(1 << i), 1'b0);
      cmp("pin", {12'h0, 20'hfffff & ~(20'h1 << (i + 5))}, {12'h0, ch_enable});
    end
    wr(oesc_pkg::REG_MGMT_EN, 32'hffffe);
    setpin(8'h04, 1'b0);
    chk(oesc_pkg::REG_EFFECTIVE, 32'hfff7e, "eff");
    setpin(8'h04, 1'b1);
    cmp("sb0", 32'hfffff, {12'h0, ch_enable});
    i_host.send(PA, 20, 1'b1);
    repeat (8) @(posedge clk_sys);
    cmp("sb1", {12'h0, PA}, {12'h0, ch_enable});
    i_host.send(PB, 20, 1'b0);
    i_host.send(PC, 10, 1'b1);
    repeat (8) @(posedge clk_sys);
    cmp("sb2", {12'h0, PA[9:0], PC[9:0]}, {12'h0, ch_enable});
    chk(oesc_pkg::REG_SB_OUT, {12'h0, PA[9:0], PC[9:0]}, "sbreg");
    pg <= 1'b0;
    repeat (8) @(posedge clk_sys);
    cmp("pd", 32'h1, {31'h0, powerdown});
    cmp("off", 32'h0, {12'h0, ch_enable});
    chk(oesc_pkg::REG_STATUS, 32'hf, "status");
    pg <= 1'b1;
    repeat (8) @(posedge clk_sys);
    cmp("back", {12'h0, PA[9:0], PC[9:0]}, {12'h0, ch_enable});
    close_out();
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      close_out();
    end
  end
endmodule
